// ### logic/uit_regs.sv
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - masked status 24-16 shows nine core sources ANDed with masks
// - masked status 12-9 shows four receive sources ANDed with masks
// - masked status 4-0 shows five transmit sources; read-only, reset zero
// - writing zero to core end-of-interrupt vector acknowledges it
// - control bit 0 enables transmit DMA; other bits reserved
// - teardown bit 31 is a ready flag, reset one, read-only
// - channel 0..3 written to teardown bits 1-0 starts teardown while ready bit 31 is one
// - writing zero to DMA end-of-interrupt vector acknowledges DMA
// - vector register is a registered copy of the vector input
// - writing ones to mask-set sets those mask bits
// - writing ones to mask-clear clears those mask bits
module uit_regs
  import uit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] irq_sources,
  input wire logic [31:0] tx_irq_vector_in,
  input wire logic teardown_done,
  output logic tx_dma_enable,
  output logic teardown_start,
  output logic [1:0] teardown_channel,
  output logic usb_eoi_ack,
  output logic dma_eoi_ack,
  output logic irq
);
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] masked_q;
  logic en_q;
  logic ready_q;
  logic [1:0] chan_q;
  logic start_q;
  logic [31:0] vec_q;
  logic [2:0] evt_q;
  logic [2:0] evt_d;
  logic [2:0] emask_q;
  logic [31:0] rdata_q;
  logic [7:0] usb_vec;
  logic [7:0] dma_vec;

  // apb decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire [7:0] a = paddr[7:0];
  wire hit = (paddr[31:8] == 24'h0000_00) && (a[1:0] == 2'b00) &&
    (a <= OFF_EVT_MASK);
  wire wr_set = wr && a == OFF_IRQ_MASK_SET;
  wire wr_clr = wr && a == OFF_IRQ_MASK_CLEAR;
  wire wr_usb_eoi = wr && a == OFF_USB_EOI;
  wire wr_ctrl = wr && a == OFF_TX_DMA_CTRL;
  wire wr_td = wr && a == OFF_TX_DMA_TD && ready_q;
  wire wr_dma_eoi = wr && a == OFF_DMA_EOI;
  wire wr_estat = wr && a == OFF_EVT_STATUS;
  wire wr_emask = wr && a == OFF_EVT_MASK;

  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  // mask set and clear; clear wins if both, though both in one write is impossible
  always_comb begin
    mask_d = mask_q;
    if (wr_set) begin
      mask_d = mask_q | (pwdata & SRC_VALID);
    end
    if (wr_clr) begin
      mask_d = mask_q & ~(pwdata & SRC_VALID);
    end
  end

  // events: hardware set wins over write-one clear
  wire [2:0] evt_set = {teardown_done, dma_eoi_ack, usb_eoi_ack};
  always_comb begin
    evt_d = evt_q;
    if (wr_estat) begin
      evt_d = evt_q & ~pwdata[2:0];
    end
    evt_d = evt_d | evt_set;
  end

  // mask, masked status, vector copy and events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= MASK_RESET;
      masked_q <= 32'h0000_0000;
      vec_q <= 32'h0000_0000;
      evt_q <= EVT_RESET;
      emask_q <= EVT_RESET;
    end else begin
      mask_q <= mask_d;
      masked_q <= irq_sources & mask_q & SRC_VALID;
      vec_q <= tx_irq_vector_in;
      evt_q <= evt_d;
      if (wr_emask) begin
        emask_q <= pwdata[2:0];
      end
    end
  end

  // dma enable and teardown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      ready_q <= 1'b1;
      chan_q <= 2'b00;
      start_q <= 1'b0;
    end else begin
      start_q <= wr_td;
      if (wr_ctrl) begin
        en_q <= pwdata[0];
      end
      if (wr_td) begin
        chan_q <= pwdata[TD_CHAN_W-1:0];
        ready_q <= 1'b0;
      end else if (teardown_done) begin
        ready_q <= 1'b1;
      end
    end
  end

  // end-of-interrupt fields
  uit_eoi_field u_usb_eoi (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr_usb_eoi),
    .wdata(pwdata[7:0]),
    .vec(usb_vec),
    .ack(usb_eoi_ack)
  );
  uit_eoi_field u_dma_eoi (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr_dma_eoi),
    .wdata(pwdata[7:0]),
    .vec(dma_vec),
    .ack(dma_eoi_ack)
  );

  // read mux; reserved bits zero
  wire [31:0] rmux =
    (a == OFF_IRQ_MASK) ? mask_q :
    (a == OFF_MASKED_STATUS) ? masked_q :
    (a == OFF_USB_EOI) ? {24'h00_0000, usb_vec} :
    (a == OFF_TX_DMA_CTRL) ? {31'h0000_0000, en_q} :
    (a == OFF_TX_DMA_TD) ? {ready_q, 29'h0000_0000, chan_q} :
    (a == OFF_DMA_EOI) ? {24'h00_0000, dma_vec} :
    (a == OFF_TX_DMA_VEC) ? vec_q :
    (a == OFF_EVT_STATUS) ? {29'h0000_0000, evt_q} :
    (a == OFF_EVT_MASK) ? {29'h0000_0000, emask_q} : 32'h0000_0000;

  // read data register, loaded on the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= hit ? rmux : 32'h0000_0000;
    end
  end

  assign prdata = rdata_q;
  assign tx_dma_enable = en_q;
  assign teardown_start = start_q;
  assign teardown_channel = chan_q;
  assign irq = |(evt_q & emask_q);

  mask_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_set && !wr_clr |=> (mask_q & $past(pwdata) & SRC_VALID)
      == ($past(pwdata) & SRC_VALID))
    else $error("mask set failed");
  mask_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_clr |=> (mask_q & $past(pwdata)) == 32'h0000_0000)
    else $error("mask clear failed");
  masked_val_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> masked_q == ($past(irq_sources) & $past(mask_q) & SRC_VALID))
    else $error("masked status wrong");
  dma_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> tx_dma_enable == $past(pwdata[0]))
    else $error("dma enable wrong");
  td_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_td |=> !ready_q && teardown_start)
    else $error("teardown ready not cleared");
  td_chan_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_td |=> teardown_channel == $past(pwdata[1:0]))
    else $error("teardown channel wrong");
  vec_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 vec_q == $past(tx_irq_vector_in))
    else $error("vector copy wrong");
  usb_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_usb_eoi && pwdata[7:0] == 8'h00 |=> usb_eoi_ack)
    else $error("usb eoi ack missing");
  dma_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_dma_eoi && pwdata[7:0] == 8'h00 |=> dma_eoi_ack)
    else $error("dma eoi ack missing");
  resv_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mask_q & ~SRC_VALID) == 32'h0000_0000)
    else $error("reserved mask bits set");
endmodule : uit_regs

// ### include/uit_pkg.sv
package uit_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_IRQ_MASK = 8'h00;
  localparam logic [7:0] OFF_IRQ_MASK_SET = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK_CLEAR = 8'h08;
  localparam logic [7:0] OFF_MASKED_STATUS = 8'h0C;
  localparam logic [7:0] OFF_USB_EOI = 8'h10;
  localparam logic [7:0] OFF_TX_DMA_CTRL = 8'h14;
  localparam logic [7:0] OFF_TX_DMA_TD = 8'h18;
  localparam logic [7:0] OFF_DMA_EOI = 8'h1C;
  localparam logic [7:0] OFF_TX_DMA_VEC = 8'h20;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h24;
  localparam logic [7:0] OFF_EVT_MASK = 8'h28;
  // layout of interrupt source fields
  localparam logic [31:0] SRC_VALID = 32'h01FF_1E1F;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam int EOI_W = 8;
  localparam int TD_READY_BIT = 31;
  localparam int TD_CHAN_W = 2;
  // event status bits
  localparam int EVT_USB_EOI = 0;
  localparam int EVT_DMA_EOI = 1;
  localparam int EVT_TD_DONE = 2;
  localparam int EVT_W = 3;
  localparam logic [2:0] EVT_RESET = 3'h0;
endpackage : uit_pkg

// ### logic/uit_eoi_field.sv
`timescale 1ns/1ps
// one end-of-interrupt vector field with acknowledge pulse
module uit_eoi_field
  import uit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [7:0] vec,
  output logic ack
);
  logic [7:0] vec_q;
  logic ack_q;

  // field store; acknowledge only on a zero write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      ack_q <= wr && (wdata == 8'h00);
      if (wr) begin
        vec_q <= wdata;
      end
    end
  end

  assign vec = vec_q;
  assign ack = ack_q;

  zero_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr ##1 1'b1 |-> ack == ($past(wdata) == 8'h00))
    else $error("eoi acknowledge mismatch");
endmodule : uit_eoi_field

// ### tb/tb_usb_irq_ack_and_tx_dma_ctrl.sv
`timescale 1ns/1ps
module tb_usb_irq_ack_and_tx_dma_ctrl;
  import uit_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic teardown_done, tx_dma_enable, teardown_start;
  logic usb_eoi_ack, dma_eoi_ack;
  logic [1:0] teardown_channel;
  logic [31:0] paddr, pwdata, prdata, irq_sources, tx_irq_vector_in, rd;
  int errors, samples_checked, cycles;

  uit_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_sources(irq_sources), .tx_irq_vector_in(tx_irq_vector_in),
    .teardown_done(teardown_done), .tx_dma_enable(tx_dma_enable),
    .teardown_start(teardown_start), .teardown_channel(teardown_channel),
    .usb_eoi_ack(usb_eoi_ack), .dma_eoi_ack(dma_eoi_ack), .irq(irq));

  // value compare, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready seen high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rchk

  // mask set/clear and masked view of sources
  task automatic t_masks;
    rchk(OFF_MASKED_STATUS, 32'h0000_0000);
    xfer(1'b1, OFF_IRQ_MASK_SET, 32'hFFFF_FFFF);
    rchk(OFF_IRQ_MASK, SRC_VALID);
    xfer(1'b1, OFF_IRQ_MASK_CLEAR, 32'h0001_0201);
    xfer(1'b1, OFF_IRQ_MASK_SET, 32'h0000_0000);
    rchk(OFF_IRQ_MASK, 32'h01FE_1C1E);
    xfer(1'b1, OFF_IRQ_MASK_CLEAR, 32'h0000_0000);
    rchk(OFF_MASKED_STATUS, 32'h01FE_1C1E);
    irq_sources <= 32'h0003_0603;
    xfer(1'b1, OFF_MASKED_STATUS, 32'hFFFF_FFFF);
    rchk(OFF_MASKED_STATUS, 32'h0002_0402);
  endtask : t_masks

  // nonzero write is no acknowledge, zero write is
  task automatic t_eoi(input int i);
    logic [7:0] a;
    a = (i == 1) ? OFF_DMA_EOI : OFF_USB_EOI;
    rchk(a, 32'h0000_0000);
    xfer(1'b1, a, 32'hFFFF_FF5A);
    #1 chk({dma_eoi_ack, usb_eoi_ack}, 32'h0);
    rchk(a, 32'h0000_005A);
    xfer(1'b1, a, 32'h0000_0000);
    #1 chk({dma_eoi_ack, usb_eoi_ack}, 32'h1 << i);
    @(posedge pclk);
    #1 chk({dma_eoi_ack, usb_eoi_ack}, 32'h0);
  endtask : t_eoi

  // sticky events, mask, level irq, write-one clear
  task automatic t_events;
    rchk(OFF_EVT_STATUS, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, OFF_EVT_MASK, 32'h0000_0007);
    #1 chk({31'h0, irq}, 32'h1);
    xfer(1'b1, OFF_EVT_STATUS, 32'h0000_0003);
    #1 chk({31'h0, irq}, 32'h0);
    rchk(OFF_EVT_STATUS, 32'h0000_0000);
  endtask : t_events

  // enable bit and reserved control bits
  task automatic t_ctrl;
    rchk(OFF_TX_DMA_CTRL, 32'h0000_0000);
    xfer(1'b1, OFF_TX_DMA_CTRL, 32'hFFFF_FFFF);
    #1 chk({31'h0, tx_dma_enable}, 32'h1);
    rchk(OFF_TX_DMA_CTRL, 32'h0000_0001);
    xfer(1'b1, OFF_TX_DMA_CTRL, 32'h0000_0000);
    #1 chk({31'h0, tx_dma_enable}, 32'h0);
  endtask : t_ctrl

  // every channel, refused write while busy, completion
  task automatic t_teardown;
    rchk(OFF_TX_DMA_TD, 32'h8000_0000);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, OFF_TX_DMA_TD, 32'h7FFF_FFFC | c);
      #1 chk({teardown_start, teardown_channel}, 32'h4 | c);
      rchk(OFF_TX_DMA_TD, c);
      xfer(1'b1, OFF_TX_DMA_TD, c ^ 1);
      rchk(OFF_TX_DMA_TD, c);
      teardown_done <= 1'b1;
      @(posedge pclk);
      teardown_done <= 1'b0;
      rchk(OFF_TX_DMA_TD, 32'h8000_0000 | c);
    end
    rchk(OFF_EVT_STATUS, 32'h0000_0004);
    xfer(1'b1, OFF_EVT_STATUS, 32'h0000_0004);
  endtask : t_teardown

  // vector copy, read-only, and an unmapped address
  task automatic t_misc;
    tx_irq_vector_in <= 32'hA5C3_0F96;
    xfer(1'b1, OFF_TX_DMA_VEC, 32'h0000_0000);
    rchk(OFF_TX_DMA_VEC, 32'hA5C3_0F96);
    rchk(8'h40, 32'h0000_0000);
    chk({31'h0, err}, 32'h1);
  endtask : t_misc

  task automatic wrap_up;
    $display("checked=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // clock source
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, teardown_done} = 5'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    irq_sources = 32'hFFFF_FFFF;
    tx_irq_vector_in = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_masks();
    t_eoi(0);
    t_eoi(1);
    t_events();
    t_ctrl();
    t_teardown();
    t_misc();
    wrap_up();
  end
endmodule : tb_usb_irq_ack_and_tx_dma_ctrl
